// ---- hw/sws_pkg.sv ----
/*
  Constants, register map and state codes for the slave watchdog and
  state control block. Assumes a single 100 MHz clock and a register
  port that addresses 16-bit registers by their printed offsets.
*/
package sws_pkg;
  localparam int REG_AW = 12;
  localparam logic [11:0] OFS_PRESCALER = 12'h400;
  localparam logic [11:0] OFS_LOCAL_COUNT = 12'h410;
  localparam logic [11:0] OFS_NET_COUNT = 12'h420;
  localparam logic [11:0] OFS_STATUS = 12'h430;
  localparam logic [11:0] OFS_STATE = 12'h440;
  localparam logic [15:0] RST_PRESCALER = 16'h09C2;
  localparam logic [15:0] RST_NET_COUNT = 16'h03E8;
  localparam logic [15:0] RST_LOCAL_COUNT = 16'h03E8;
  localparam logic [16:0] PRESC_EXTRA = 17'h00002;
  // Base tick 40 ns against the 10 ns system clock
  localparam int BASE_TICK_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BASE_LAST = 2'(BASE_CYCLES - 1);
  localparam int OUT_W = 8;
  localparam int ST_BIT_NET = 0;
  localparam int ST_BIT_LOCAL = 1;
  typedef enum logic [1:0] {
    SWS_STARTUP = 2'b00,
    SWS_PREP = 2'b01,
    SWS_GUARDED = 2'b10,
    SWS_RUN = 2'b11
  } sws_state_t;
endpackage : sws_pkg

// ---- hw/sws_top.sv ----
/*
  Watchdogs and communication state machine of the slave controller.
  Assumes accesses and requests arrive as one-cycle pulses on i_clk.
*/
`timescale 1ns/1ps
module sws_top (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic [sws_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_pd_access,
  input wire logic i_local_access,
  input wire logic i_wdog_monitor_en,
  input wire logic [1:0] i_state_req,
  input wire logic i_state_req_valid,
  input wire logic i_mbx_cfg_ok,
  input wire logic i_pd_cfg_ok,
  input wire logic i_inputs_copied,
  input wire logic [sws_pkg::OUT_W-1:0] i_out_data,
  input wire logic [sws_pkg::OUT_W-1:0] i_safe_value,
  output logic o_copy_inputs,
  output logic o_mbx_allowed,
  output logic o_pd_allowed,
  output logic [1:0] o_state,
  output logic o_state_error,
  output logic o_net_triggered,
  output logic o_local_triggered,
  output logic [sws_pkg::OUT_W-1:0] o_outputs
);
  import sws_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] presc_q, presc_d;
  logic [15:0] lcnt_q, lcnt_d;
  logic [15:0] ncnt_q, ncnt_d;

  always_comb begin
    presc_d = presc_q;
    lcnt_d = lcnt_q;
    ncnt_d = ncnt_q;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        OFS_PRESCALER: presc_d = i_reg_wdata;
        OFS_LOCAL_COUNT: lcnt_d = i_reg_wdata;
        OFS_NET_COUNT: ncnt_d = i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      presc_q <= RST_PRESCALER;
      lcnt_q <= RST_LOCAL_COUNT;
      ncnt_q <= RST_NET_COUNT;
    end else begin
      presc_q <= presc_d;
      lcnt_q <= lcnt_d;
      ncnt_q <= ncnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Prescaler: base tick of 40 ns, then prescaler+2 base ticks
  logic [1:0] base_q, base_d;
  logic [16:0] pre_q, pre_d;
  logic tick_q, tick_d;
  logic base_end;

  assign base_end = (base_q == BASE_LAST);

  always_comb begin
    base_d = base_end ? 2'h0 : base_q + 2'h1;
    pre_d = pre_q;
    tick_d = 1'b0;
    if (base_end) begin
      if (pre_q + 17'h00001 >= {1'b0, presc_q} + PRESC_EXTRA) begin
        pre_d = '0;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 17'h00001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      base_q <= '0;
      pre_q <= '0;
      tick_q <= 1'b0;
    end else begin
      base_q <= base_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Watchdogs
  logic net_exp, local_exp;
  logic net_en, local_en;

  assign net_en = i_wdog_monitor_en && (ncnt_q != 16'h0000);
  assign local_en = i_wdog_monitor_en && (lcnt_q != 16'h0000);

  sws_wdog u_net_wdog (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(tick_q),
    .i_kick(i_pd_access && o_pd_allowed),
    .i_count(ncnt_q),
    .i_enable(net_en),
    .o_expired(net_exp)
  );

  sws_wdog u_local_wdog (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(tick_q),
    .i_kick(i_local_access),
    .i_count(lcnt_q),
    .i_enable(local_en),
    .o_expired(local_exp)
  );

  //////////////////////////////////////////////////////////////////////
  // Slave state machine
  sws_state_t st_q, st_d;
  logic err_q, err_d;
  logic pend_q, pend_d;

  always_comb begin
    st_d = st_q;
    err_d = err_q;
    pend_d = pend_q;
    if (pend_q) begin
      if (i_inputs_copied) begin
        st_d = SWS_GUARDED;
        pend_d = 1'b0;
      end
    end else if (i_state_req_valid) begin
      err_d = 1'b0;
      unique case (sws_state_t'(i_state_req))
        SWS_STARTUP: begin
          st_d = SWS_STARTUP;
        end
        SWS_PREP: begin
          if (st_q == SWS_STARTUP && !i_mbx_cfg_ok) begin
            err_d = 1'b1;
          end else if (st_q != SWS_PREP) begin
            st_d = SWS_PREP;
          end
        end
        SWS_GUARDED: begin
          if (st_q == SWS_PREP && i_pd_cfg_ok) begin
            pend_d = 1'b1;
          end else if (st_q == SWS_RUN) begin
            st_d = SWS_GUARDED;
          end else if (st_q != SWS_GUARDED) begin
            err_d = 1'b1;
          end
        end
        SWS_RUN: begin
          if (st_q == SWS_GUARDED) begin
            st_d = SWS_RUN;
          end else if (st_q != SWS_RUN) begin
            err_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= SWS_STARTUP;
      err_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      err_q <= err_d;
      pend_q <= pend_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Traffic gates, taken from the next state so they change with st_q
  logic mbx_q, mbx_d;
  logic pd_q, pd_d;

  always_comb begin
    mbx_d = (st_d != SWS_STARTUP);
    // process traffic in guarded and run
    pd_d = (st_d == SWS_GUARDED) || (st_d == SWS_RUN);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mbx_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      mbx_q <= mbx_d;
      pd_q <= pd_d;
    end
  end

  assign o_mbx_allowed = mbx_q;
  assign o_pd_allowed = pd_q;
  assign o_copy_inputs = pend_q;
  assign o_state = st_q;
  assign o_state_error = err_q;
  assign o_net_triggered = net_exp;
  assign o_local_triggered = local_exp;

  //////////////////////////////////////////////////////////////////////
  // Outputs
  logic [OUT_W-1:0] out_q, out_d;
  logic drive_ok;

  always_comb begin
    drive_ok = (st_q == SWS_RUN) || (st_q == SWS_GUARDED && !i_wdog_monitor_en);
    out_d = i_out_data;
    if (!drive_ok || net_exp || local_exp) begin
      out_d = i_safe_value;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign o_outputs = out_q;

  //////////////////////////////////////////////////////////////////////
  // Read mux, registered: the value at an offset shows one edge later
  logic [15:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 16'h0000;
    unique case (i_reg_addr)
      OFS_PRESCALER: rdata_d = presc_q;
      OFS_LOCAL_COUNT: rdata_d = lcnt_q;
      OFS_NET_COUNT: rdata_d = ncnt_q;
      OFS_STATUS: begin
        rdata_d[ST_BIT_NET] = net_exp;
        rdata_d[ST_BIT_LOCAL] = local_exp;
      end
      OFS_STATE: rdata_d[1:0] = st_q;
      default: ;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
endmodule : sws_top

// ---- hw/sws_wdog.sv ----
/*
  One watchdog timer: counts prescaled ticks and latches an expiry flag.
  Assumes the tick strobe comes from the shared prescaler on one clock.
*/
`timescale 1ns/1ps
module sws_wdog (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_kick,
  input wire logic [15:0] i_count,
  input wire logic i_enable,
  output logic o_expired
);
  import sws_pkg::*;
  logic [15:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (i_kick || !i_enable) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (i_tick && !exp_q) begin
      if (cnt_q + 16'h0001 >= i_count) begin
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;
endmodule : sws_wdog

// ---- sim/sws_assertions.sv ----
/* Checker on the sws_top ports: state gating, flags and outputs.
   Assumes it is bound to sws_top; one clock, async active-low reset. */
`timescale 1ns/1ps
module sws_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_state_req_valid,
  input wire logic i_pd_access,
  input wire logic i_wdog_monitor_en,
  input wire logic i_inputs_copied,
  input wire logic [sws_pkg::OUT_W-1:0] i_out_data,
  input wire logic [sws_pkg::OUT_W-1:0] i_safe_value,
  input wire logic o_mbx_allowed,
  input wire logic o_pd_allowed,
  input wire logic [1:0] o_state,
  input wire logic o_net_triggered,
  input wire logic o_local_triggered,
  input wire logic [sws_pkg::OUT_W-1:0] o_outputs
);
  import sws_pkg::*;
  logic trig;
  assign trig = o_net_triggered || o_local_triggered;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  sequence enter_guard_s;
    o_state == SWS_PREP ##1 o_state == SWS_GUARDED;
  endsequence
  startup_quiet_a: assert property (
    o_state == SWS_STARTUP |-> !o_mbx_allowed && !o_pd_allowed) else $error("startup traffic");
  prep_mailbox_a: assert property (
    o_state == SWS_PREP |-> o_mbx_allowed && !o_pd_allowed) else $error("prep traffic");
  traffic_open_a: assert property (
    o_state[1] |-> o_mbx_allowed && o_pd_allowed) else $error("traffic closed");
  guard_entry_a: assert property (
    enter_guard_s |-> $past(i_inputs_copied)) else $error("guarded before copy");
  net_state_kept_a: assert property (
    $rose(o_net_triggered) && !$past(i_state_req_valid) && !$past(i_inputs_copied)
    |-> $stable(o_state)) else $error("state moved on expiry");
  net_sticky_a: assert property (
    o_net_triggered && !i_pd_access && i_wdog_monitor_en |=> o_net_triggered)
    else $error("flag dropped");
  safe_force_a: assert property (
    $past(trig) && trig |-> o_outputs == $past(i_safe_value)) else $error("not safe");
  run_copy_a: assert property (
    $past(o_state) == SWS_RUN && o_state == SWS_RUN && !$past(trig) && !trig
    |-> o_outputs == $past(i_out_data)) else $error("run outputs");
  guarded_safe_a: assert property (
    $past(o_state) == SWS_GUARDED && o_state == SWS_GUARDED && $past(i_wdog_monitor_en)
    && i_wdog_monitor_en |-> o_outputs == $past(i_safe_value)) else $error("guarded out");
endmodule : sws_assertions

bind sws_top sws_assertions u_sws_chk (.i_clk, .i_reset_n, .i_state_req_valid, .i_pd_access,
  .i_wdog_monitor_en, .i_inputs_copied, .i_out_data, .i_safe_value, .o_mbx_allowed,
  .o_pd_allowed, .o_state, .o_net_triggered, .o_local_triggered, .o_outputs);

// ---- sim/sws_partner.sv ----
/* Far side: network master and local processor access pulses.
   Assumes the bench enables each stream; output data held valid. */
`timescale 1ns/1ps
module sws_partner (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pd_on,
  input wire logic i_local_on,
  output logic o_pd_access,
  output logic o_local_access,
  output logic [sws_pkg::OUT_W-1:0] o_out_data
);
  import sws_pkg::*;
  assign o_out_data = 8'h5A;
  ////////////////////////////////////////
  // cyclic accesses
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pd_access <= 1'b0;
      o_local_access <= 1'b0;
    end else begin
      o_pd_access <= i_pd_on && !o_pd_access;
      o_local_access <= i_local_on && !o_local_access;
    end
  end
endmodule : sws_partner

// ---- sim/sws_top_bench.sv ----
/* Self-checking bench for sws_top: registers, states, watchdogs.
   Assumes sws_partner for the far side and the bound checker. */
`timescale 1ns/1ps
module sws_top_bench;
  import sws_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_wdog_monitor_en = 1'b1;
  logic i_state_req_valid = 1'b0, i_mbx_cfg_ok = 1'b0, i_pd_cfg_ok = 1'b0;
  logic i_inputs_copied = 1'b0, pd_on = 1'b1, local_on = 1'b1;
  logic [11:0] i_reg_addr = 12'h400;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic [1:0] i_state_req = 2'h0, o_state;
  logic [OUT_W-1:0] i_safe_value = 8'hC3, i_out_data, o_outputs;
  logic i_pd_access, i_local_access, o_copy_inputs, o_mbx_allowed, o_pd_allowed;
  logic o_state_error, o_net_triggered, o_local_triggered;
  int error_cnt = 0, total_checks = 0;
  always #5 i_clk = ~i_clk;
  sws_top DUT (.i_clk, .i_reset_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_pd_access, .i_local_access, .i_wdog_monitor_en, .i_state_req, .i_state_req_valid,
    .i_mbx_cfg_ok, .i_pd_cfg_ok, .i_inputs_copied, .i_out_data, .i_safe_value, .o_copy_inputs,
    .o_mbx_allowed, .o_pd_allowed, .o_state, .o_state_error, .o_net_triggered,
    .o_local_triggered, .o_outputs);
  sws_partner u_partner (.i_clk, .i_reset_n, .i_pd_on(pd_on), .i_local_on(local_on),
    .o_pd_access(i_pd_access), .o_local_access(i_local_access), .o_out_data(i_out_data));
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    step(1);
    i_reg_wr = 1'b0;
    step(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] exp);
    i_reg_addr = a;
    step(1);
    check(o_reg_rdata, exp);
  endtask : rd_reg
  task automatic req(input logic [1:0] s);
    i_state_req = s;
    i_state_req_valid = 1'b1;
    step(1);
    i_state_req_valid = 1'b0;
    step(1);
  endtask : req
  task automatic st_is(input logic [3:0] e);
    check({12'h000, o_state, o_mbx_allowed, o_pd_allowed}, {12'h000, e});
  endtask : st_is
  task automatic fl_is(input logic [1:0] e);
    check({14'h0000, o_local_triggered, o_net_triggered}, {14'h0000, e});
  endtask : fl_is
  task automatic wait_flag(input bit loc);
    int n;
    for (n = 0; n < 80 && (loc ? o_local_triggered : o_net_triggered) !== 1'b1; n++) step(1);
    if (n == 80) begin
      error_cnt++;
      complete_run();
    end
  endtask : wait_flag
  ////////////////////////////////////////
  initial begin
    step(8);
    i_reset_n = 1'b1;
    rd_reg(OFS_PRESCALER, 16'h09C2);
    rd_reg(OFS_NET_COUNT, 16'h03E8);
    rd_reg(OFS_LOCAL_COUNT, 16'h03E8);
    rd_reg(12'h404, 16'h0000);
    st_is({SWS_STARTUP, 2'b00});
    // Tick of two base periods keeps timeouts short
    wr_reg(OFS_PRESCALER, 16'h0000);
    wr_reg(OFS_NET_COUNT, 16'h0003);
    rd_reg(OFS_PRESCALER, 16'h0000);
    rd_reg(OFS_NET_COUNT, 16'h0003);
    req(SWS_PREP);
    st_is({SWS_STARTUP, 2'b00});
    check({15'h0000, o_state_error}, 16'h0001);
    i_mbx_cfg_ok = 1'b1;
    req(SWS_PREP);
    st_is({SWS_PREP, 2'b10});
    check({15'h0000, o_state_error}, 16'h0000);
    req(SWS_GUARDED);
    check({15'h0000, o_state_error}, 16'h0001);
    check({15'h0000, o_copy_inputs}, 16'h0000);
    st_is({SWS_PREP, 2'b10});
    req(SWS_RUN);
    st_is({SWS_PREP, 2'b10});
    i_pd_cfg_ok = 1'b1;
    req(SWS_GUARDED);
    check({15'h0000, o_copy_inputs}, 16'h0001);
    st_is({SWS_PREP, 2'b10});
    i_inputs_copied = 1'b1;
    step(1);
    i_inputs_copied = 1'b0;
    step(1);
    check({15'h0000, o_copy_inputs}, 16'h0000);
    st_is({SWS_GUARDED, 2'b11});
    check(16'(o_outputs), 16'h00C3);
    i_wdog_monitor_en = 1'b0;
    step(2);
    check(16'(o_outputs), 16'h005A);
    i_wdog_monitor_en = 1'b1;
    step(2);
    req(SWS_RUN);
    st_is({SWS_RUN, 2'b11});
    check(16'(o_outputs), 16'h005A);
    rd_reg(OFS_STATE, 16'h0003);
    pd_on = 1'b0;
    step(14);
    fl_is(2'b00);
    wait_flag(1'b0);
    step(1);
    st_is({SWS_RUN, 2'b11});
    check(16'(o_outputs), 16'h00C3);
    rd_reg(OFS_STATUS, 16'h0001);
    step(30);
    fl_is(2'b01);
    pd_on = 1'b1;
    step(4);
    fl_is(2'b00);
    wr_reg(OFS_NET_COUNT, 16'h0000);
    pd_on = 1'b0;
    step(60);
    fl_is(2'b00);
    wr_reg(OFS_LOCAL_COUNT, 16'hFFFF);
    rd_reg(OFS_LOCAL_COUNT, 16'hFFFF);
    wr_reg(OFS_LOCAL_COUNT, 16'h0003);
    local_on = 1'b0;
    wait_flag(1'b1);
    step(1);
    rd_reg(OFS_STATUS, 16'h0002);
    check(16'(o_outputs), 16'h00C3);
    local_on = 1'b1;
    step(4);
    fl_is(2'b00);
    req(SWS_GUARDED);
    st_is({SWS_GUARDED, 2'b11});
    check({15'h0000, o_state_error}, 16'h0000);
    check(16'(o_outputs), 16'h00C3);
    req(SWS_PREP);
    st_is({SWS_PREP, 2'b10});
    req(SWS_STARTUP);
    st_is({SWS_STARTUP, 2'b00});
    complete_run();
  end
endmodule : sws_top_bench
